// >>> verilog/cond_branch_params.svh
// constants for the flag-clear conditional branch decoder
// Overview of operation
// [RULE_01] upper byte E7 decodes as negative-clear branch
// [RULE_02] negative-clear branch taken only when negative is zero
// [RULE_03] offset is signed byte, -128 to 127
// [RULE_04] taken target is incremented counter plus twice offset
// [RULE_05] one word; one cycle, two when taken
// [RULE_06] four phases, then four idle phases if taken
// [RULE_07] upper byte E5 is overflow-clear branch
// [RULE_08] upper byte E1 is zero-clear branch
// [RULE_09] not taken: counter advances to next instruction
// [RULE_10] upper byte E3 is carry-clear branch
// [RULE_11] status flags are never modified
// [RULE_12] taken branch discards the prefetched instruction
`ifndef COND_BRANCH_PARAMS_SVH
`define COND_BRANCH_PARAMS_SVH
`define OP_NEG_CLEAR 8'hE7
`define OP_OVF_CLEAR 8'hE5
`define OP_ZERO_CLEAR 8'hE1
`define OP_CARRY_CLEAR 8'hE3
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002
`define PHASE_COUNT 4
`endif

// >>> verilog/cond_branch_pkg.sv
// types shared by the flag-clear branch decoder
package cond_branch_pkg;
   // instruction phase within one instruction cycle
   typedef enum logic [1:0] {
      PH_DECODE = 2'b00,
      PH_READ = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE = 2'b11
   } phase_t;
   // cycle kind: normal execute or pipeline flush
   typedef enum logic [0:0] {
      CY_EXEC = 1'b0,
      CY_FLUSH = 1'b1
   } cycle_t;
endpackage : cond_branch_pkg

// >>> verilog/flag_select.sv
// flag selector: decodes the opcode prefix and picks the tested flag
`timescale 1ns/1ns
`include "cond_branch_params.svh"
module flag_select (
   // instruction prefix
   input wire logic [7:0] prefix,
   // status flags
   input wire logic flag_neg,
   input wire logic flag_ovf,
   input wire logic flag_zero,
   input wire logic flag_carry,
   // results
   output logic is_branch,
   output logic cond_true
);
   // one prefix per flag; the flag must be clear to branch
   always_comb begin
      is_branch = 1'b1;
      cond_true = 1'b0;
      case (prefix)
         `OP_NEG_CLEAR: cond_true = ~flag_neg; // [RULE_01] [RULE_02]
         `OP_OVF_CLEAR: cond_true = ~flag_ovf; // [RULE_07]
         `OP_ZERO_CLEAR: cond_true = ~flag_zero; // [RULE_08]
         `OP_CARRY_CLEAR: cond_true = ~flag_carry; // [RULE_10]
         default: is_branch = 1'b0;
      endcase
   end
endmodule : flag_select

// >>> verilog/cond_branch_flag_clear.sv
// flag-clear conditional branch execute unit with four-phase timing
`timescale 1ns/1ns
`include "cond_branch_params.svh"
module cond_branch_flag_clear #(
   // counter width in bits; the target math needs at least nine
   parameter int PC_WIDTH = 21
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // instruction word, valid at the decode phase
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   // status flags, read only
   input wire logic flag_neg,
   input wire logic flag_ovf,
   input wire logic flag_zero,
   input wire logic flag_carry,
   // program counter state
   output logic [PC_WIDTH-1:0] program_counter,
   output cond_branch_pkg::phase_t phase,
   output logic flush,
   output logic taken,
   output logic done
);
   import cond_branch_pkg::*;

   // one branch, one clock per phase of the phase counter:
   //   decode  - prefix and flags sampled, the fetch steps the counter
   //   read    - offset literal captured
   //   process - target settles on pc_next
   //   write   - target written when taken, otherwise nothing happens
   // a taken branch then spends a flush cycle of four idle phases in which
   // decode is blocked, so the word fetched behind the branch is dropped
   // the counter is an output register: consumers see the target one clock
   // after the write edge, in the same clock as the taken pulse

   // decode phase of an execute cycle: the only slot that accepts a word
   function automatic logic exec_decode(input phase_t ph, input cycle_t cy);
      return ph == PH_DECODE && cy == CY_EXEC;
   endfunction : exec_decode

   // write phase of an execute cycle whose branch was decided as taken
   function automatic logic taken_write(input phase_t ph, input cycle_t cy,
         input logic tk);
      return ph == PH_WRITE && cy == CY_EXEC && tk;
   endfunction : taken_write

   logic is_branch; // prefix is one of the four branches
   logic cond_true; // selected flag is clear
   logic [7:0] offset_reg; // latched offset literal
   logic hit_reg; // latched decode result
   logic take_reg; // latched branch decision
   cycle_t cycle_reg; // execute or flush cycle
   logic [PC_WIDTH-1:0] offset_ext; // twice the offset, sign extended
   logic [PC_WIDTH-1:0] pc_next; // next counter value

   // decode runs combinationally from the instruction word
   flag_select u_sel (
      .prefix(instr[15:8]),
      .flag_neg(flag_neg),
      .flag_ovf(flag_ovf),
      .flag_zero(flag_zero),
      .flag_carry(flag_carry),
      .is_branch(is_branch),
      .cond_true(cond_true)
   );

   // phase counter walks the four phases every cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= PH_DECODE;
      end else begin
         phase <= phase_t'(phase + 2'b01); // [RULE_06]
      end
   end

   // decode and literal capture; flags only sampled, never written
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hit_reg <= 1'b0;
         take_reg <= 1'b0;
         offset_reg <= 8'h00;
      end else if (exec_decode(phase, cycle_reg)) begin
         // a word offered in a flush cycle never reaches this branch
         hit_reg <= instr_valid & is_branch;
         take_reg <= instr_valid & is_branch & cond_true; // [RULE_11]
      end else if (phase == PH_READ) begin
         // also runs in flush cycles; harmless, no write follows there
         offset_reg <= instr[7:0]; // [RULE_03]
      end
   end

   // target: counter already points past the branch, add 2n signed
   always_comb begin
      // offsets count words, so shift left once; sign bit fills the top
      offset_ext = {{(PC_WIDTH-9){offset_reg[7]}}, offset_reg,
         1'b0}; // [RULE_03]
      // wraps modulo the counter width, as the address space does
      pc_next = program_counter + offset_ext; // [RULE_04]
   end

   // counter update: fetch step at decode, target write at the last phase of an execute cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         program_counter <= PC_WIDTH'(`PC_RESET);
      end else if (exec_decode(phase, cycle_reg)) begin
         // fetch increment happens as the cycle starts
         program_counter <= program_counter
            + PC_WIDTH'(`PC_STEP); // [RULE_09]
      end else if (taken_write(phase, cycle_reg, take_reg)) begin
         // taken: the target replaces the word the fetch pointed at
         program_counter <= pc_next; // [RULE_04]
      end
   end

   // cycle kind: a taken branch is followed by one flush cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cycle_reg <= CY_EXEC;
         flush <= 1'b0;
      end else if (phase == PH_WRITE) begin
         if (taken_write(phase, cycle_reg, take_reg)) begin
            // the next four phases are idle; decode stays blocked
            cycle_reg <= CY_FLUSH; // [RULE_05] [RULE_12]
            flush <= 1'b1;
         end else begin
            // untaken end, or end of the flush: back to execute
            cycle_reg <= CY_EXEC;
            flush <= 1'b0;
         end
      end
   end

   // status pulses: taken marks the counter write, done ends the op
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         taken <= 1'b0;
         done <= 1'b0;
      end else begin
         // both pulses last one clock; done closes recognised branches only
         taken <= taken_write(phase, cycle_reg, take_reg); // [RULE_05]
         done <= phase == PH_WRITE && hit_reg
            && (cycle_reg == CY_FLUSH || !take_reg); // [RULE_05]
      end
   end

   // checks below watch the registers this block drives; sampled values
   // keep them one clock behind the logic, so each consequent looks at
   // the clock after the edge that its antecedent describes

   // counter write of a taken branch, outside reset
   sequence s_taken_write;
      !rst && taken_write(phase, cycle_reg, take_reg);
   endsequence : s_taken_write

   // one whole flush cycle: four idle phases in a row
   sequence s_flush_run;
      flush [*4];
   endsequence : s_flush_run

   // fetch slot of an execute cycle, outside reset
   sequence s_fetch_slot;
      !rst && exec_decode(phase, cycle_reg);
   endsequence : s_fetch_slot

   // taken branch: flush must follow the counter write
   a_flush_follow: assert property ( // [RULE_12]
      @(posedge clk) disable iff (rst)
      taken |-> s_flush_run)
      else $error("flush cycle missing after taken branch");

   // counter never moves during a flush cycle except at its start
   a_flush_quiet: assert property ( // [RULE_06]
      @(posedge clk) disable iff (rst)
      (flush && $past(flush)) |-> $stable(program_counter))
      else $error("counter changed during flush");

   // taken write lands at incremented counter plus twice offset
   a_target_math: assert property ( // [RULE_04]
      @(posedge clk) disable iff (rst)
      taken |-> program_counter == $past(program_counter)
         + PC_WIDTH'(signed'({$past(offset_reg), 1'b0})))
      else $error("wrong branch target");

   // not taken ends after one cycle with no flush
   a_not_taken: assert property ( // [RULE_09]
      @(posedge clk) disable iff (rst)
      (done && !$past(flush)) |-> !flush)
      else $error("flush after untaken branch");

   // the taken write raises taken and flush together
   a_taken_write: assert property ( // [RULE_12]
      @(posedge clk) disable iff (rst)
      s_taken_write |=> taken && flush)
      else $error("taken write without flush cycle");

   // taken pulse follows the write phase, as the next cycle starts
   a_taken_phase: assert property ( // [RULE_06]
      @(posedge clk) disable iff (rst)
      taken |-> phase == PH_DECODE && $past(phase) == PH_WRITE)
      else $error("taken pulse out of phase");

   // done lasts one clock, so a consumer counts each branch once
   a_done_pulse: assert property ( // [RULE_05]
      @(posedge clk) disable iff (rst)
      done |=> !done)
      else $error("done held longer than one clock");

   // every execute cycle fetches: the counter steps by one word
   a_fetch_step: assert property ( // [RULE_09]
      @(posedge clk) disable iff (rst)
      s_fetch_slot |=> program_counter
         == $past(program_counter) + PC_WIDTH'(`PC_STEP))
      else $error("counter did not step at decode");

   // a write phase that takes nothing leaves the counter alone
   a_hold_untaken: assert property ( // [RULE_09]
      @(posedge clk) disable iff (rst)
      (!rst && phase == PH_WRITE
         && !taken_write(phase, cycle_reg, take_reg))
      |=> $stable(program_counter))
      else $error("counter moved in an untaken write phase");

   // a decode slot of the flush cycle keeps the latched decision
   a_decode_blocked: assert property ( // [RULE_12]
      @(posedge clk) disable iff (rst)
      (!rst && phase == PH_DECODE && cycle_reg == CY_FLUSH)
      |=> $stable(take_reg) && $stable(hit_reg))
      else $error("decode accepted during flush");
endmodule : cond_branch_flag_clear

// >>> tb/cond_branch_flag_clear_tb_top.sv
// self-checking bench for the flag-clear branch decoder
`timescale 1ns/1ns
`include "cond_branch_params.svh"
module cond_branch_flag_clear_tb_top;
   import cond_branch_pkg::*;
   logic clk = 0, rst = 1, instr_valid = 0;
   logic [15:0] instr = 16'h0000;
   logic [3:0] flags = 4'h0; // neg, ovf, zero, carry
   logic [20:0] program_counter;
   phase_t phase;
   logic flush, taken, done;
   int n_fail = 0, compares = 0;
   cond_branch_flag_clear #(.PC_WIDTH(21)) i_dut (.clk(clk), .rst(rst),
      .instr(instr), .instr_valid(instr_valid), .flag_neg(flags[3]),
      .flag_ovf(flags[2]), .flag_zero(flags[1]), .flag_carry(flags[0]),
      .program_counter(program_counter), .phase(phase), .flush(flush),
      .taken(taken), .done(done));
   initial forever #25 clk = ~clk;
   task chk_pc(input string what, input logic [20:0] exp, got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_pc
   task chk_bit(input string what, input logic exp, got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   // one branch in a free slot; the counter is read after the write phase
   // because the next sequential decode may bump it again
   task run(input logic [7:0] op, off, input logic [3:0] fl,
            input logic go, known);
      logic [20:0] p0, pa, pe;
      logic st, sf, sd;
      int n;
      st = 0; sf = 0; sd = 0; n = 0; pa = '0;
      do @(posedge clk); while (phase !== PH_WRITE || flush !== 1'b0);
      p0 = program_counter;
      instr <= {op, off};
      flags <= fl;
      instr_valid <= 1'b1;
      for (int i = 1; i <= (known ? 12 : 5) && !sd; i++) begin
         @(posedge clk);
         if (i == 1) instr_valid <= 1'b0;
         #1;
         if (i == 1) chk_pc("phase", 21'(PH_READ), 21'(phase));
         if (i == 4) pa = program_counter;
         st |= (taken === 1'b1);
         sf |= (flush === 1'b1);
         sd = (done === 1'b1);
         n = i;
      end
      pe = go ? p0 + 21'h2 + {{12{off[7]}}, off, 1'b0} : p0 + 21'h2;
      chk_pc("pc", pe, pa);
      chk_bit("taken", go, st);
      chk_bit("flush", go, sf);
      chk_bit("done", known, sd);
      if (known) chk_pc("cycles", go ? 21'h8 : 21'h4, 21'(n));
   endtask : run
   // each opcode: taken with only its flag clear, idle with it set
   task t_opcodes;
      logic [7:0] ops [4];
      ops = '{`OP_NEG_CLEAR, `OP_OVF_CLEAR, `OP_ZERO_CLEAR, `OP_CARRY_CLEAR};
      for (int k = 0; k < 4; k++) begin
         run(ops[k], 8'h05, ~(4'h8 >> k), 1'b1, 1'b1);
         run(ops[k], 8'hFB, 4'h8 >> k, 1'b0, 1'b1);
      end
      $display("opcodes test ended");
   endtask : t_opcodes
   // offset extremes, one idle execute cycle apart
   task t_offsets;
      run(`OP_ZERO_CLEAR, 8'h80, 4'h0, 1'b1, 1'b1);
      run(`OP_CARRY_CLEAR, 8'h7F, 4'h0, 1'b1, 1'b1);
      $display("offsets test ended");
   endtask : t_offsets
   // a branch word still offered in the flush slot must be dropped
   task t_flush;
      logic [20:0] p0;
      do @(posedge clk); while (phase !== PH_WRITE || flush !== 1'b0);
      instr <= {`OP_NEG_CLEAR, 8'h04};
      flags <= 4'h0;
      instr_valid <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      p0 = program_counter;
      chk_bit("flush slot flush", 1'b1, flush);
      @(posedge clk);
      instr_valid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_pc("flush slot pc", p0, program_counter);
      chk_bit("flush slot done", 1'b1, done);
      $display("flush test ended");
   endtask : t_flush
   // a flag-set prefix is not ours and only advances the counter
   task t_unknown;
      run(8'hE6, 8'h10, 4'h0, 1'b0, 1'b0);
      $display("unknown test ended");
   endtask : t_unknown
   task results;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   // watchdog: the tests need well under a thousand cycles
   initial begin
      #(5000 * 50);
      n_fail++;
      results();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_opcodes();
      t_offsets();
      t_flush();
      t_unknown();
      results();
   end
endmodule : cond_branch_flag_clear_tb_top
